// ### core/serial_tx_pkg.sv
// Purpose: Shared constants and types of the asynchronous serial port.
// Assumes: Registers sit on a 3-bit word address of a plain strobe port.
// Notes:   Bit positions follow the control register layouts used by the core.
package serial_tx_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register word addresses
   localparam logic [ADDR_W-1:0] OFS_RX_CTRL   = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_TX_HOLD   = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_TX_CTRL   = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_BAUD_CTRL = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_DIV_HIGH  = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_DIV_LOW   = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_RX_READ   = 3'h6;
   localparam logic [ADDR_W-1:0] OFS_INT_EN    = 3'h7;

   // receive_status_control fields
   localparam int RC_SERIAL_PORT_ENABLE  = 7;
   localparam int RC_RX9   = 6;
   localparam int RC_CONTINUOUS_RECEIVE_ENABLE  = 4;
   localparam int RC_FERR  = 2;
   localparam int RC_OERR  = 1;
   localparam int RC_RX9D  = 0;
   localparam logic [7:0] RC_WMASK = 8'hf8;

   // transmit_status_control fields
   localparam int TC_TX9   = 6;
   localparam int TC_TRANSMIT_ENABLE_BIT  = 5;
   localparam int TC_SYNC  = 4;
   localparam int TC_HIGH_BAUD_SELECT  = 2;
   localparam int TC_SHIFT_EMPTY_STATUS  = 1;
   localparam int TC_TRANSMIT_NINTH_BIT  = 0;
   localparam logic [7:0] TC_WMASK = 8'hfd;

   // baud_control fields
   localparam int BC_RCIDL = 6;
   localparam int BC_DTRXP = 5;
   localparam int BC_TRANSMIT_POLARITY_INVERT = 4;
   localparam int BC_WIDE_DIVIDER_SELECT = 3;
   localparam logic [7:0] BC_WMASK = 8'h3b;

   // Interrupt enable register fields
   localparam int IE_GIE   = 7;
   localparam int IE_PERIPHERAL_INTERRUPT_ENABLE  = 6;
   localparam int IE_RCIE  = 5;
   localparam int IE_TRANSMIT_INTERRUPT_ENABLE  = 4;
   localparam logic [7:0] IE_WMASK = 8'hf0;

   // Reset values
   localparam logic [7:0] RST_RX_CTRL   = 8'h00;
   localparam logic [7:0] RST_TX_CTRL   = 8'h00;
   localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
   localparam logic [7:0] RST_DIV       = 8'h00;
   localparam logic [7:0] RST_INT_EN    = 8'h00;

   // Timing: clocks per oversample tick is PRESC_x * (divisor + 1)
   localparam logic [2:0] PRESC_SLOW   = 3'h4;
   localparam logic [2:0] PRESC_FAST   = 3'h1;
   localparam logic [3:0] TICKS_LAST   = 4'hf;
   localparam logic [3:0] RX_VOTE_TICK = 4'h8;
   localparam logic [3:0] FRAME_BITS8  = 4'ha;
   localparam logic [3:0] FRAME_BITS9  = 4'hb;
   localparam logic [3:0] DATA_BITS8   = 4'h8;
   localparam logic [3:0] DATA_BITS9   = 4'h9;
   localparam logic [1:0] FIFO_DEPTH   = 2'h2;

   typedef enum logic {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

endpackage

// ### core/serial_port.sv
// Purpose: Asynchronous serial transmitter with the front end of its receiver.
// Assumes: clk_i is the system clock; pin inputs are asynchronous to it.
// Notes:   All state lives in one packed struct updated by a single flop process.
`timescale 1ns/1ps

module serial_port
   import serial_tx_pkg::*;
(
   input  wire logic                             clk_i,
   input  wire logic                             rstn_i,
   input  wire logic [serial_tx_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [serial_tx_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                             we_i,
   input  wire logic                             re_i,
   output logic      [serial_tx_pkg::DATA_W-1:0] rdata_o,
   output logic                                  tx_pin_o,
   output logic                                  tx_pin_oe_o,
   input  wire logic                             tx_latch_i,
   input  wire logic                             tx_dir_i,
   input  wire logic                             rx_pin_i,
   output logic                                  rx_pin_o,
   output logic                                  rx_pin_oe_o,
   input  wire logic                             rx_latch_i,
   input  wire logic                             rx_dir_i,
   output logic                                  tx_flag_o,
   output logic                                  rx_flag_o,
   output logic                                  tx_irq_o,
   output logic                                  rx_irq_o
);
   import serial_tx_pkg::*;

   typedef struct packed {
      logic [7:0]       rx_ctrl;
      logic [7:0]       tx_ctrl;
      logic [7:0]       baud_ctrl;
      logic [7:0]       div_high;
      logic [7:0]       div_low;
      logic [7:0]       int_en;
      logic [8:0]       hold;
      logic             hold_full;
      logic             transmit_buffer_empty_flag;
      tx_state_t        tx_st;
      logic [10:0]      frame;
      logic [3:0]       tx_bits;
      logic [22:0]      tx_cnt;
      logic [18:0]      pre_cnt;
      logic             rx_s1;
      logic             rx_s2;
      rx_state_t        rx_st;
      logic [3:0]       rx_tick;
      logic [3:0]       rx_bits;
      logic [1:0]       votes;
      logic [8:0]       receive_shift_register;
      logic [1:0][9:0]  fifo;
      logic             head;
      logic [1:0]       fcount;
      logic             oerr;
      logic [7:0]       rdata;
   } state_t;

   state_t q;
   state_t d;
   // Every register of the block sits in q and d is its next value; one flop
   // process keeps reset and clocking uniform across transmit and receive

   // Clocks per oversample tick; the slow prescale applies only in narrow low-rate mode
   // The product fits 17 bits: the slow prescale only ever meets the 8-bit divisor
   function automatic logic [18:0] tick_cycles(input logic [7:0] bctl,
                                               input logic [7:0] tctl,
                                               input logic [7:0] hi,
                                               input logic [7:0] lo);
      logic [16:0] div;
      logic [2:0]  presc;
      div   = bctl[BC_WIDE_DIVIDER_SELECT] ? {1'b0, hi, lo} : {9'h000, lo};
      div   = div + 17'h00001;
      presc = (!bctl[BC_WIDE_DIVIDER_SELECT] && !tctl[TC_HIGH_BAUD_SELECT]) ? PRESC_SLOW : PRESC_FAST;
      return 19'(div * presc);
   endfunction

   // Two-of-three majority of the samples taken around bit centre
   function automatic logic maj3(input logic [1:0] v, input logic s);
      return (v[0] & v[1]) | (v[0] & s) | (v[1] & s);
   endfunction

   // Decoded enables and single-cycle strobes, recomputed from q every cycle
   logic        serial_port_enable;
   logic        tx_on;
   logic        rx_on;
   logic        tick;
   logic        rx_line;
   logic        frame_done;
   logic        pop;
   logic        push;
   logic        bit_s;
   logic [22:0] bit_len;
   logic [18:0] tick_len;
   logic [8:0]  rx_word;
   logic        wr_idx;

   always_comb begin
      d          = q;
      serial_port_enable       = q.rx_ctrl[RC_SERIAL_PORT_ENABLE];
      tx_on      = q.tx_ctrl[TC_TRANSMIT_ENABLE_BIT] & ~q.tx_ctrl[TC_SYNC] & serial_port_enable;
      // receive gating
      // An overrun holds the receiver off until the receive enable or the port enable is cleared
      rx_on      = q.rx_ctrl[RC_CONTINUOUS_RECEIVE_ENABLE] & ~q.tx_ctrl[TC_SYNC] & serial_port_enable & ~q.oerr;
      tick_len   = tick_cycles(q.baud_ctrl, q.tx_ctrl, q.div_high, q.div_low);
      // one baud period
      // Sixteen oversample ticks per bit, the same span the receiver counts
      bit_len    = {tick_len, 4'h0};
      tick       = (q.pre_cnt == tick_len - 19'h00001);
      rx_line    = q.rx_s2 ^ q.baud_ctrl[BC_DTRXP];
      frame_done = 1'b0;
      pop        = 1'b0;
      push       = 1'b0;
      bit_s      = 1'b0;
      rx_word    = 9'h000;
      wr_idx     = 1'b0;

      // Register writes; read-only status bits are masked out
      // A holding write is always taken here; the abort below drops it again
      // while the transmitter is off
      if (we_i) begin
         case (addr_i)
            OFS_RX_CTRL:   d.rx_ctrl = wdata_i & RC_WMASK;
            OFS_TX_CTRL:   d.tx_ctrl = wdata_i & TC_WMASK;
            OFS_BAUD_CTRL: d.baud_ctrl = wdata_i & BC_WMASK;
            OFS_DIV_HIGH:  d.div_high = wdata_i;
            OFS_DIV_LOW:   d.div_low = wdata_i;
            OFS_INT_EN:    d.int_en = wdata_i & IE_WMASK;
            OFS_TX_HOLD: begin
               d.hold      = {q.tx_ctrl[TC_TRANSMIT_NINTH_BIT], wdata_i};
               d.hold_full = 1'b1;
            end
            default: ;
         endcase
      end

      // Transmit shifter
      // The frame shifts right with mark fill, so frame[0] is the bit on the line
      // and the line falls back to mark by itself after the stop bit
      if (q.tx_st == TX_SHIFT) begin
         if (q.tx_cnt == bit_len - 23'h000001) begin
            d.tx_cnt  = 23'h000000;
            d.frame   = {1'b1, q.frame[10:1]};
            d.tx_bits = q.tx_bits - 4'h1;
            if (q.tx_bits == 4'h1) begin
               frame_done = 1'b1;
               d.tx_st    = TX_IDLE;
            end
         end else begin
            d.tx_cnt = q.tx_cnt + 23'h000001;
         end
      end

      // queued load right after stop bit
      // Testing d.hold_full lets a write to an idle shifter load at its own edge,
      // so the start bit reaches the line one cycle after the write
      if (tx_on && d.hold_full && (q.tx_st == TX_IDLE || frame_done)) begin
         d.hold_full = 1'b0;
         d.tx_st     = TX_SHIFT;
         d.tx_cnt    = 23'h000000;
         if (q.tx_ctrl[TC_TX9]) begin
            d.frame   = {1'b1, d.hold, 1'b0};
            d.tx_bits = FRAME_BITS9;
         end else begin
            d.frame   = {2'b11, d.hold[7:0], 1'b0};
            d.tx_bits = FRAME_BITS8;
         end
      end

      // abort on disable
      // The queued character goes too; software reloads after re-enabling
      if (!tx_on) begin
         d.tx_st     = TX_IDLE;
         d.frame     = '1;
         d.tx_cnt    = 23'h000000;
         d.tx_bits   = 4'h0;
         d.hold_full = 1'b0;
      end

      // one stage behind the write
      // Built from the registered holding state, which gives the one-cycle lag
      // after a holding write that software is told to expect
      d.transmit_buffer_empty_flag = tx_on & ~q.hold_full;

      // Receive oversample prescaler, free running while the port is on
      d.pre_cnt = tick ? 19'h00000 : q.pre_cnt + 19'h00001;
      // Two flops before any use; nothing but rx_s2 reads rx_s1
      d.rx_s1   = rx_pin_i;
      d.rx_s2   = q.rx_s1;

      case (q.rx_st)
         RX_IDLE: begin
            d.rx_tick = 4'h0;
            if (rx_on && !rx_line) begin
               d.rx_st = RX_START;
            end
         end
         RX_START: begin
            if (tick) begin
               d.rx_tick = q.rx_tick + 4'h1;
               // Half a bit in: a glitch aborts without error
               if (q.rx_tick == RX_VOTE_TICK - 4'h1) begin
                  d.rx_tick = 4'h0;
                  d.rx_bits = 4'h0;
                  d.rx_st   = rx_line ? RX_IDLE : RX_DATA;
               end
            end
         end
         RX_DATA, RX_STOP: begin
            if (tick) begin
               d.rx_tick = q.rx_tick + 4'h1;
               if (q.rx_tick == TICKS_LAST - 4'h2) begin
                  d.votes[0] = rx_line;
               end
               if (q.rx_tick == TICKS_LAST - 4'h1) begin
                  d.votes[1] = rx_line;
               end
               if (q.rx_tick == TICKS_LAST) begin
                  // Three-sample vote around bit centre rejects line noise
                  bit_s     = maj3(q.votes, rx_line);
                  d.rx_tick = 4'h0;
                  if (q.rx_st == RX_DATA) begin
                     d.receive_shift_register     = {bit_s, q.receive_shift_register[8:1]};
                     d.rx_bits = q.rx_bits + 4'h1;
                     if (q.rx_bits == (q.rx_ctrl[RC_RX9] ? DATA_BITS9 : DATA_BITS8) - 4'h1) begin
                        d.rx_st = RX_STOP;
                     end
                  end else begin
                     push    = 1'b1;
                     d.rx_st = RX_IDLE;
                  end
               end
            end
         end
         default: d.rx_st = RX_IDLE;
      endcase

      // Register reads; reading the receive register pops the FIFO
      // Shift-empty and receiver idle are live state, not stored bits
      if (re_i) begin
         case (addr_i)
            OFS_RX_CTRL:   d.rdata = {q.rx_ctrl[7:3], q.fifo[q.head][9] & (q.fcount != 2'h0),
                                      q.oerr, q.fifo[q.head][8] & (q.fcount != 2'h0)};
            OFS_TX_CTRL: begin
               d.rdata          = q.tx_ctrl;
               d.rdata[TC_SHIFT_EMPTY_STATUS] = (q.tx_st == TX_IDLE);
            end
            OFS_BAUD_CTRL: begin
               d.rdata           = q.baud_ctrl;
               d.rdata[BC_RCIDL] = (q.rx_st == RX_IDLE);
            end
            OFS_DIV_HIGH:  d.rdata = q.div_high;
            OFS_DIV_LOW:   d.rdata = q.div_low;
            OFS_INT_EN:    d.rdata = q.int_en;
            OFS_RX_READ: begin
               d.rdata = q.fifo[q.head][7:0];
               pop     = (q.fcount != 2'h0);
            end
            default:       d.rdata = 8'h00;
         endcase
      end

      // two-entry receive FIFO
      // A pop and a push in one cycle work from the post-pop head and count
      // An overrun drops the third character whole; the receiver then stays
      // off until the receive enable or the port enable is cleared
      if (pop) begin
         d.head   = ~q.head;
         d.fcount = q.fcount - 2'h1;
      end
      if (push) begin
         rx_word = q.rx_ctrl[RC_RX9] ? d.receive_shift_register : {1'b0, d.receive_shift_register[8:1]};
         if (d.fcount == FIFO_DEPTH) begin
            d.oerr = 1'b1;
         end else begin
            wr_idx          = d.head ^ d.fcount[0];
            d.fifo[wr_idx]  = {~bit_s, rx_word};
            d.fcount        = d.fcount + 2'h1;
         end
      end
      if (!q.rx_ctrl[RC_CONTINUOUS_RECEIVE_ENABLE]) begin
         d.oerr = 1'b0;
      end
      if (!rx_on && q.rx_st != RX_IDLE) begin
         d.rx_st = RX_IDLE;
      end

      // Port disable resets receive side, prescaler and error state
      // Characters still waiting in the FIFO are lost at that point
      if (!serial_port_enable) begin
         d.pre_cnt = 19'h00000;
         d.fcount  = 2'h0;
         d.head    = 1'b0;
         d.oerr    = 1'b0;
         d.fifo    = '0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q           <= '0;
         q.rx_ctrl   <= RST_RX_CTRL;
         q.tx_ctrl   <= RST_TX_CTRL;
         q.baud_ctrl <= RST_BAUD_CTRL;
         q.div_high  <= RST_DIV;
         q.div_low   <= RST_DIV;
         q.int_en    <= RST_INT_EN;
         q.tx_st     <= TX_IDLE;
         q.rx_st     <= RX_IDLE;
         q.frame     <= '1;
         // Synchroniser starts at mark so no false start follows reset
         q.rx_s1     <= 1'b1;
         q.rx_s2     <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata_o     = q.rdata;
   // Pin outputs mix flops with the pin controls, so a port enable change
   // reaches the pin in the very next cycle
   // port drives transmit pin
   assign tx_pin_oe_o = serial_port_enable | ~tx_dir_i;
   assign tx_pin_o    = serial_port_enable ? ((q.tx_st == TX_SHIFT ? q.frame[0] : 1'b1) ^ q.baud_ctrl[BC_TRANSMIT_POLARITY_INVERT])
                             : tx_latch_i;
   assign rx_pin_oe_o = ~serial_port_enable & ~rx_dir_i;
   assign rx_pin_o    = rx_latch_i;
   assign tx_flag_o   = q.transmit_buffer_empty_flag;
   assign rx_flag_o   = q.rx_ctrl[RC_CONTINUOUS_RECEIVE_ENABLE] & serial_port_enable & (q.fcount != 2'h0);
   assign tx_irq_o    = q.transmit_buffer_empty_flag & q.int_en[IE_TRANSMIT_INTERRUPT_ENABLE] & q.int_en[IE_PERIPHERAL_INTERRUPT_ENABLE] & q.int_en[IE_GIE];
   assign rx_irq_o    = rx_flag_o & q.int_en[IE_RCIE] & q.int_en[IE_PERIPHERAL_INTERRUPT_ENABLE] & q.int_en[IE_GIE];

endmodule

// ### tb/serial_port_assertions.sv
// Purpose: Port-level checker for the serial transmitter.
// Assumes: Control registers are shadowed from the strobe bus.
// Notes:   Bit timing checks only judge the 16-clocks-per-bit setting.
`timescale 1ns/1ps
module serial_port_checker
   import serial_tx_pkg::*;
(
   input wire logic                             clk_i,
   input wire logic                             rstn_i,
   input wire logic [serial_tx_pkg::ADDR_W-1:0] addr_i,
   input wire logic [serial_tx_pkg::DATA_W-1:0] wdata_i,
   input wire logic                             we_i,
   input wire logic                             tx_pin_o,
   input wire logic                             tx_pin_oe_o,
   input wire logic                             rx_pin_oe_o,
   input wire logic                             tx_flag_o,
   input wire logic                             tx_irq_o
);
   logic [7:0]  rc_q, tc_q, bc_q, lo_q, ie_q;
   logic        last_q, idle_q, txon, fast, mark;
   logic [11:0] run_q;

   assign txon = rc_q[RC_SERIAL_PORT_ENABLE] && tc_q[TC_TRANSMIT_ENABLE_BIT] && !tc_q[TC_SYNC];
   assign fast = tc_q[TC_HIGH_BAUD_SELECT] && !bc_q[BC_WIDE_DIVIDER_SELECT] && lo_q == 8'h00;
   assign mark = !bc_q[BC_TRANSMIT_POLARITY_INVERT];

   // Shadow copies lag nothing: they update at the same edge as the core
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rc_q   <= 8'h00;
         tc_q   <= 8'h00;
         bc_q   <= 8'h00;
         lo_q   <= 8'h00;
         ie_q   <= 8'h00;
         last_q <= 1'b0;
         idle_q <= 1'b0;
         run_q  <= 12'h000;
      end else begin
         last_q <= tx_pin_o;
         idle_q <= rc_q[RC_SERIAL_PORT_ENABLE] && !txon;
         if (tx_pin_o != last_q) begin
            run_q <= 12'h001;
         end else if (run_q != 12'hfff) begin
            run_q <= run_q + 12'h001;
         end
         if (we_i) begin
            case (addr_i)
               OFS_RX_CTRL:   rc_q <= wdata_i & RC_WMASK;
               OFS_TX_CTRL:   tc_q <= wdata_i & TC_WMASK;
               OFS_BAUD_CTRL: bc_q <= wdata_i & BC_WMASK;
               OFS_DIV_LOW:   lo_q <= wdata_i;
               OFS_INT_EN:    ie_q <= wdata_i & IE_WMASK;
               default: ;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_port_drives: assert property (rc_q[RC_SERIAL_PORT_ENABLE] |-> tx_pin_oe_o)
      else $error("transmit pin not driven with port on");
   a_rx_input: assert property (rc_q[RC_SERIAL_PORT_ENABLE] |-> !rx_pin_oe_o)
      else $error("receive pin driven with port on");
   a_enable_flag: assert property (we_i && addr_i == OFS_TX_CTRL && wdata_i[TC_TRANSMIT_ENABLE_BIT] && !wdata_i[TC_SYNC]
      && rc_q[RC_SERIAL_PORT_ENABLE] && !tc_q[TC_TRANSMIT_ENABLE_BIT] |=> ##1 tx_flag_o)
      else $error("empty flag not set after transmit enable");
   a_load_start: assert property (we_i && addr_i == OFS_TX_HOLD && txon && fast && last_q == mark
      && tx_pin_o == mark && run_q >= 12'h0aa
      |=> tx_pin_o != mark ##16 tx_pin_o == ($past(wdata_i[0], 17) ^ !mark))
      else $error("start or first data bit wrong after idle load");
   a_flag_queue: assert property (we_i && addr_i == OFS_TX_HOLD && txon && tx_pin_o != mark
      && tx_flag_o |=> tx_flag_o ##1 !tx_flag_o)
      else $error("empty flag timing wrong on queued write");
   a_bit_width: assert property (fast && txon && $past(txon) && $stable(bc_q) && tx_pin_o != last_q
      && last_q != mark |-> run_q[3:0] == 4'h0 && run_q != 12'h000)
      else $error("space run not a whole number of bit periods");
   a_idle_mark: assert property (rc_q[RC_SERIAL_PORT_ENABLE] && !txon && idle_q && $stable(bc_q)
      |-> tx_pin_o == mark)
      else $error("line not at mark while transmitter off");
   a_irq_gate: assert property (tx_irq_o == (tx_flag_o && ie_q[IE_TRANSMIT_INTERRUPT_ENABLE] && ie_q[IE_PERIPHERAL_INTERRUPT_ENABLE] && ie_q[IE_GIE]))
      else $error("transmit request does not follow flag and enables");

   c_queue: cover property (txon && $fell(tx_flag_o));
   c_irq: cover property ($rose(tx_irq_o));
   c_start: cover property (txon && fast && last_q == mark && tx_pin_o != mark);
endmodule

bind serial_port serial_port_checker u_serial_port_checker (
   .clk_i       (clk_i),
   .rstn_i      (rstn_i),
   .addr_i      (addr_i),
   .wdata_i     (wdata_i),
   .we_i        (we_i),
   .tx_pin_o    (tx_pin_o),
   .tx_pin_oe_o (tx_pin_oe_o),
   .rx_pin_oe_o (rx_pin_oe_o),
   .tx_flag_o   (tx_flag_o),
   .tx_irq_o    (tx_irq_o)
);

// ### tb/serial_peer.sv
// Purpose: Remote asynchronous transceiver on the serial line.
// Assumes: Fixed bit length in system clocks.
// Notes:   Decodes by sampling mid-bit; send is called by the bench.
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic        clk_i,
   input  wire logic        line_i,
   input  wire logic        inv_i,
   input  wire logic        nine_i,
   output logic             line_o,
   output logic [8:0]       word_o,
   output int unsigned      count_o,
   output int unsigned      bad_o
);
   logic [8:0] w;
   int         i;

   initial begin
      line_o  = 1'b1;
      word_o  = '0;
      count_o = 0;
      bad_o   = 0;
   end

   always begin
      @(posedge clk_i);
      if ((line_i ^ inv_i) == 1'b0) begin
         repeat (BIT_CLKS / 2 - 1) @(posedge clk_i);
         // A glitch shorter than half a bit is no start
         if ((line_i ^ inv_i) == 1'b0) begin
            w = '0;
            for (i = 0; i < (nine_i ? 9 : 8); i++) begin
               repeat (BIT_CLKS) @(posedge clk_i);
               w[i] = line_i ^ inv_i;
            end
            repeat (BIT_CLKS) @(posedge clk_i);
            if ((line_i ^ inv_i) != 1'b1) begin
               bad_o++;
            end
            word_o = w;
            count_o++;
         end
      end
   end

   task automatic send(input logic [8:0] v, input int n);
      int k;
      @(posedge clk_i);
      line_o <= 1'b0;
      for (k = 0; k < n; k++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         line_o <= v[k];
      end
      repeat (BIT_CLKS) @(posedge clk_i);
      line_o <= 1'b1;
      repeat (2 * BIT_CLKS) @(posedge clk_i);
   endtask
endmodule

// ### tb/test_serial_port.sv
// Purpose: Register-driven test of the serial transmitter.
// Assumes: Divisor 0 with high-rate select gives 16 clocks per bit.
// Notes:   Frames are judged by the peer model on the line.
`timescale 1ns/1ps
module test_serial_port;
   import serial_tx_pkg::*;
   logic              clk_i, rstn_i, we_i, re_i, rx_pin_i;
   logic [ADDR_W-1:0] addr_i;
   logic [7:0]        wdata_i, rdata_o, v;
   logic              tx_pin_o, tx_pin_oe_o, rx_pin_o, rx_pin_oe_o, tx_flag_o, rx_flag_o, tx_irq_o, rx_irq_o;
   logic              inv, nine;
   logic [8:0]        word;
   int unsigned       cnt, bad, n, miscompares, checked;
   logic [7:0]        pat [4] = '{8'h5a, 8'ha5, 8'h81, 8'h3c};

   serial_port u_serial_port (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
      .tx_latch_i(1'b1), .tx_dir_i(1'b1), .rx_pin_i(rx_pin_i), .rx_pin_o(rx_pin_o),
      .rx_pin_oe_o(rx_pin_oe_o), .rx_latch_i(1'b0), .rx_dir_i(1'b0), .tx_flag_o(tx_flag_o),
      .rx_flag_o(rx_flag_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

   serial_peer u_serial_peer (.clk_i(clk_i), .line_i(tx_pin_o), .inv_i(inv), .nine_i(nine),
      .line_o(rx_pin_i), .word_o(word), .count_o(cnt), .bad_o(bad));

   task automatic chk(input string s, input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      // Align to a rising edge so every strobe starts right after one
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      we_i    <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      re_i   <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
      @(posedge clk_i);
   endtask

   task automatic wait_cnt(input int unsigned m);
      int i;
      for (i = 0; i < 1000 && cnt < m; i++) @(posedge clk_i);
      chk("frames", 9'(cnt), 9'(m));
   endtask

   task automatic conclude();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      conclude();
   end

   initial begin
      rstn_i = 1'b0; we_i = 1'b0; re_i = 1'b0; addr_i = '0; wdata_i = 8'h00;
      inv = 1'b0; nine = 1'b0; miscompares = 0; checked = 0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      chk("tx_oe_off", tx_pin_oe_o, 1'b0);
      chk("rx_oe_off", rx_pin_oe_o, 1'b1);
      chk("rx_latch", rx_pin_o, 1'b0);
      rd(OFS_BAUD_CTRL, v);
      chk("baud_rst", v, {1'b0, RST_BAUD_CTRL} | (9'h001 << BC_RCIDL));
      wr(OFS_DIV_LOW, 8'h00);
      wr(OFS_DIV_HIGH, 8'h00);
      wr(OFS_RX_CTRL, 8'h90);
      @(negedge clk_i);
      chk("tx_oe_on", tx_pin_oe_o, 1'b1);
      chk("rx_oe_on", rx_pin_oe_o, 1'b0);
      wr(OFS_TX_CTRL, 8'h24);
      @(negedge clk_i);
      chk("flag_en", tx_flag_o, 1'b1);
      wr(OFS_INT_EN, 8'hd0);
      @(negedge clk_i);
      chk("irq_on", tx_irq_o, 1'b1);
      wr(OFS_INT_EN, 8'hcf);
      rd(OFS_INT_EN, v);
      chk("ie_ro", v, 8'hc0);
      chk("irq_off", tx_irq_o, 1'b0);
      chk("flag_kept", tx_flag_o, 1'b1);
      for (int k = 0; k < 4; k++) begin
         inv  <= k[0];
         nine <= k[1];
         wr(OFS_BAUD_CTRL, {3'h0, k[0], 4'h0});
         wr(OFS_TX_CTRL, {1'b0, k[1], 6'h25});
         n = cnt;
         wr(OFS_TX_HOLD, pat[k]);
         rd(OFS_TX_CTRL, v);
         chk("shift_empty_status_busy", v[TC_SHIFT_EMPTY_STATUS], 1'b0);
         wait_cnt(n + 1);
         chk("word", word, {k[1], pat[k]});
         repeat (12) @(posedge clk_i);
         rd(OFS_TX_CTRL, v);
         chk("shift_empty_status_idle", v[TC_SHIFT_EMPTY_STATUS], 1'b1);
      end
      inv <= 1'b0;
      nine <= 1'b0;
      wr(OFS_BAUD_CTRL, 8'h00);
      wr(OFS_TX_CTRL, 8'h24);
      repeat (200) @(posedge clk_i);
      n = cnt;
      wr(OFS_TX_HOLD, 8'h96);
      wr(OFS_TX_HOLD, 8'h0f);
      @(negedge clk_i);
      chk("flag_full", tx_flag_o, 1'b0);
      wait_cnt(n + 1);
      chk("first", word, 9'h096);
      wait_cnt(n + 2);
      chk("second", word, 9'h00f);
      chk("flag_free", tx_flag_o, 1'b1);
      chk("stop_bits", 9'(bad), 9'h000);
      repeat (30) @(posedge clk_i);
      wr(OFS_TX_HOLD, 8'h00);
      repeat (40) @(posedge clk_i);
      wr(OFS_RX_CTRL, 8'h10);
      @(negedge clk_i);
      chk("abort_pin", tx_pin_o, 1'b1);
      wr(OFS_RX_CTRL, 8'h90);
      @(negedge clk_i);
      chk("abort_mark", tx_pin_o, 1'b1);
      rd(OFS_TX_CTRL, v);
      chk("abort_shift_empty_status", v[TC_SHIFT_EMPTY_STATUS], 1'b1);
      repeat (200) @(posedge clk_i);
      wr(OFS_TX_CTRL, 8'h04);
      n = cnt;
      wr(OFS_TX_HOLD, 8'h55);
      repeat (200) @(posedge clk_i);
      chk("dropped", 9'(cnt), 9'(n));
      u_serial_peer.send(9'h0c3, 8);
      u_serial_peer.send(9'h03c, 8);
      chk("rx_flag", rx_flag_o, 1'b1);
      chk("rx_irq_off", rx_irq_o, 1'b0);
      rd(OFS_RX_READ, v);
      chk("rx_first", v, 8'hc3);
      rd(OFS_RX_READ, v);
      chk("rx_second", v, 8'h3c);
      chk("rx_empty", rx_flag_o, 1'b0);
      conclude();
   end
endmodule
